// file: tb/sw_master_tb.sv
// Self-checking testbench of the single-wire bus master with one slave model.
// Assumes the package, the design and the slave model are compiled first.
`timescale 1ns/1ps
module sw_master_tb;
  import sw_master_pkg::*;
  // ****************************************************************
  // Stimulus and checks
  // ****************************************************************
  logic        i_clk_sys;
  logic        i_nrst;
  logic        i_cmd_valid;
  cmd_t        i_cmd;
  logic        i_rd_ready;
  wire         i_dq;
  logic        o_cmd_ready;
  logic        o_done;
  logic        o_presence;
  logic [7:0]  o_crc;
  logic        o_rd_valid;
  logic [7:0]  o_rd_data;
  logic        o_dq_o;
  logic        o_dq_oe;
  logic        pull;
  logic        present;
  logic [7:0]  wait_us;
  logic [63:0] rom;
  int          mismatches;
  int          samples_checked;
  // The tick is shortened so that the whole run stays short; all spans scale with it.
  localparam int US_CYC = 2;
  localparam int LIM    = 20000;

  // The pull-up wins only when nobody pulls the line low.
  assign i_dq = (o_dq_oe ? o_dq_o : 1'b1) & ~pull;

  sw_master #(
    .TICK_CYCLES (US_CYC)
  ) u_sw_master (
    .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
    .o_cmd_ready(o_cmd_ready), .o_done(o_done), .o_presence(o_presence), .o_crc(o_crc),
    .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .i_rd_ready(i_rd_ready),
    .i_dq(i_dq), .o_dq_o(o_dq_o), .o_dq_oe(o_dq_oe));

  sw_slave_model #(
    .US_T (US_CYC * CLK_PERIOD_NS)
  ) u_sw_slave_model (
    .i_line(i_dq), .i_present(present), .i_wait_us(wait_us), .i_rom(rom), .o_pull(pull));

  function automatic logic [7:0] crc56(input logic [55:0] v);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 56; i++) c = (c >> 1) ^ ((c[0] ^ v[i]) ? CRC_POLY : 8'h00);
    return c;
  endfunction

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic span(input logic lvl, output int n);
    n = 0;
    while (o_dq_oe === lvl && n < LIM) begin
      @(negedge i_clk_sys);
      n++;
    end
    if (n >= LIM) check("span_limit", 0, 1);
  endtask

  task automatic wait_done(output int n);
    n = 0;
    while (o_done !== 1'b1 && n < LIM) begin
      @(negedge i_clk_sys);
      n++;
    end
    if (n >= LIM) check("done_limit", 0, 1);
  endtask

  task automatic send(input op_t op, input logic [7:0] d);
    @(negedge i_clk_sys);
    while (o_cmd_ready !== 1'b1) @(negedge i_clk_sys);
    i_cmd_valid = 1'b1;
    i_cmd       = '{op: op, data: d};
    @(negedge i_clk_sys);
    i_cmd_valid = 1'b0;
  endtask

  task automatic do_reset(input logic pres, input logic [7:0] w);
    int lo;
    int hi;
    present = pres;
    wait_us = w;
    send(OP_RESET, 8'h00);
    span(1'b0, lo);
    span(1'b1, lo);
    check("reset_low", 1, lo >= RST_LOW_US * US_CYC && lo <= RST_LOW_MAX_US * US_CYC);
    wait_done(hi);
    check("reset_high", 1, hi >= RST_HIGH_US * US_CYC);
    check("presence", pres, o_presence);
  endtask

  task automatic do_write(input logic [7:0] d);
    int lo;
    int hi;
    send(OP_WRITE, d);
    lo = 0;
    for (int i = 0; i < 8; i++) begin
      span(1'b0, hi);
      if (i > 0) check("slot", 1, lo + hi >= (SLOT_MIN_US + RECOV_MIN_US) * US_CYC
                       && hi >= RECOV_MIN_US * US_CYC);
      span(1'b1, lo);
      if (d[i]) check("one_low", 1, lo >= US_CYC && lo <= W1_LOW_MAX_US * US_CYC);
      else check("zero_low", 1, lo >= W0_LOW_US * US_CYC && lo <= W0_LOW_MAX_US * US_CYC);
    end
    wait_done(hi);
    check("write_done", 1, o_done);
  endtask

  task automatic do_read();
    int lo;
    send(OP_READ, 8'h00);
    span(1'b1, lo);
    check("read_low", 1, lo >= US_CYC && lo <= RD_SAMPLE_MAX_US * US_CYC);
    wait_done(lo);
  endtask

  task automatic pop(input logic [7:0] exp);
    int n;
    n = 0;
    while (o_rd_valid !== 1'b1 && n < 100000) begin
      @(negedge i_clk_sys);
      n++;
    end
    check("rd_valid", 1, o_rd_valid);
    check("rd_data", exp, o_rd_data);
    i_rd_ready = 1'b1;
    @(negedge i_clk_sys);
    i_rd_ready = 1'b0;
    @(negedge i_clk_sys);
  endtask

  // Reads past the 64 bits see a released line, so they fill the FIFO with ones.
  task automatic sc_rom_and_fill();
    do_write(8'h33);
    for (int i = 0; i < 33; i++) begin
      do_read();
      if (i == 7) check("crc", 8'h00, o_crc);
    end
    send(OP_READ, 8'h00);
    repeat (8 * (SLOT_US + RECOV_US) * US_CYC + 50) @(negedge i_clk_sys);
    check("full_ready", 0, o_cmd_ready);
    check("full_line", 0, o_dq_oe);
    for (int i = 0; i < 8; i++) pop(rom[8*i +: 8]);
    for (int i = 0; i < 26; i++) pop(8'hFF);
    check("ready_after", 1, o_cmd_ready);
    check("rd_empty", 0, o_rd_valid);
  endtask

  task automatic complete_run();
    if (mismatches == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  initial begin
    #1_000_000;
    mismatches++;
    complete_run();
  end

  initial begin
    i_nrst          = 1'b0;
    i_cmd_valid     = 1'b0;
    i_cmd           = '0;
    i_rd_ready      = 1'b0;
    present         = 1'b1;
    wait_us         = 8'd15;
    mismatches      = 0;
    samples_checked = 0;
    // Family code and serial number are arbitrary values.
    rom[55:0]       = 56'h12_3456_789A_BC2A;
    rom[63:56]      = crc56(rom[55:0]);
    repeat (16) @(negedge i_clk_sys);
    i_nrst = 1'b1;
    check("idle_ready", 1, o_cmd_ready);
    check("idle_line", 0, o_dq_oe);
    check("idle_dq_o", 0, o_dq_o);
    do_reset(1'b1, 8'd15);
    do_reset(1'b0, 8'd15);
    do_reset(1'b1, 8'd60);
    sc_rom_and_fill();
    complete_run();
  end
endmodule

// file: tb/sw_slave_model.sv
// Behavioural model of one identification slave on the shared line.
// Assumes the testbench resolves the line from all pull-downs and a pull-up.
`timescale 1ns/1ps
module sw_slave_model #(
  // Length of one microsecond of line time in nanoseconds.
  parameter int US_T = 1000
) (
  // Line and setup
  input  wire logic        i_line,
  input  wire logic        i_present,
  input  wire logic [7:0]  i_wait_us,
  input  wire logic [63:0] i_rom,
  // Pull-down
  output logic             o_pull
);
  // ****************************************************************
  // Slot decoding
  // ****************************************************************
  realtime    t;
  logic [7:0] cmd;
  int         nb;
  int         rd;

  initial begin
    o_pull = 1'b0;
    cmd    = 8'h00;
    nb     = 8;
    rd     = 64;
    forever begin
      @(negedge i_line);
      t = $realtime;
      if (rd < 64) begin
        o_pull = ~i_rom[rd];
        rd++;
        #(30 * US_T);
        o_pull = 1'b0;
      end else begin
        @(posedge i_line);
        t = $realtime - t;
        if (t >= 480 * US_T) begin
          nb = 0;
          if (i_present) begin
            #(i_wait_us * US_T);
            o_pull = 1'b1;
            #(120 * US_T);
            o_pull = 1'b0;
          end
        end else if (nb < 8) begin
          cmd = {t < 15 * US_T, cmd[7:1]};
          nb++;
          if (nb == 8 && cmd == 8'h33) rd = 0;
        end
      end
    end
  end
endmodule

// file: verilog/sw_byte_fifo.sv
// Byte FIFO with a registered output stage between the bus master and its user.
// Assumes DEPTH is a power of two so the pointers wrap by themselves.
`timescale 1ns/1ps
module sw_byte_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic         i_clk_sys,
  input  wire logic         i_nrst,
  // Fill side
  input  wire logic         i_in_valid,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_in_ready,
  // Drain side
  output logic              o_out_valid,
  output logic [W-1:0]      o_out_data,
  input  wire logic         i_out_ready
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [CW-1:0]           cnt;
    logic                    ov;
    logic [W-1:0]            od;
  } fifo_st_t;

  fifo_st_t q;
  fifo_st_t d;
  logic     push;
  logic     pop;

  assign o_in_ready  = (q.cnt != CW'(DEPTH));
  assign o_out_valid = q.ov;
  assign o_out_data  = q.od;

  always_comb begin
    d    = q;
    push = i_in_valid && o_in_ready;
    pop  = (q.cnt != '0) && (!q.ov || i_out_ready);
    if (q.ov && i_out_ready) begin
      d.ov = 1'b0;
    end
    if (pop) begin
      d.od = q.mem[q.rp];
      d.ov = 1'b1;
      d.rp = AW'(q.rp + 1'b1);
    end
    if (push) begin
      d.mem[q.wp] = i_in_data;
      d.wp        = AW'(q.wp + 1'b1);
    end
    if (push && !pop) begin
      d.cnt = CW'(q.cnt + 1'b1);
    end else if (pop && !push) begin
      d.cnt = CW'(q.cnt - 1'b1);
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule

// file: verilog/sw_master.sv
// Bus master for a single-wire open-drain identification link: reset/presence, write and read slots.
// Assumes an external pull-up on the line and a user that issues one byte command at a time.
`timescale 1ns/1ps
module sw_master
  import sw_master_pkg::*;
#(
  // Cycles per microsecond tick; a bench may shorten it so that whole frames fit a short run.
  parameter int TICK_CYCLES = US_CYCLES
) (
  // Clock and reset
  input  wire logic             i_clk_sys,
  input  wire logic             i_nrst,
  // Command port
  input  wire logic             i_cmd_valid,
  input  wire cmd_t             i_cmd,
  output logic                  o_cmd_ready,
  output logic                  o_done,
  output logic                  o_presence,
  output logic [7:0]            o_crc,
  // Read data
  output logic                  o_rd_valid,
  output logic [BYTE_W-1:0]     o_rd_data,
  input  wire logic             i_rd_ready,
  // Line pins
  input  wire logic             i_dq,
  output logic                  o_dq_o,
  output logic                  o_dq_oe
);

  st_t  q;
  st_t  d;
  logic tick;
  logic line;
  logic push_ready;
  logic smp_pres;
  logic smp_rd;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic at_us(input logic [US_W-1:0] us, input int n, input logic t);
    at_us = t && (us == US_W'(n - 1));
  endfunction

  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
    logic [7:0] r;
    r = c >> 1;
    if (c[0] ^ b) begin
      r = r ^ CRC_POLY;
    end
    crc_step = r;
  endfunction

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    d        = q;
    d.done   = 1'b0;
    d.sync   = {q.sync[0], i_dq};
    line     = q.sync[1];
    tick     = (q.div == DIV_W'(TICK_CYCLES - 1));
    d.div    = tick ? '0 : DIV_W'(q.div + 1'b1);
    smp_pres = 1'b0;
    smp_rd   = 1'b0;
    if (tick) begin
      d.us = US_W'(q.us + 1'b1);
    end
    case (q.phase)
      PH_IDLE: begin
        d.div = '0;
        d.us  = '0;
        if (i_cmd_valid && q.cmd_ready) begin
          d.cmd_ready = 1'b0;
          d.bitn      = '0;
          d.sh        = i_cmd.data;
          d.rd        = (i_cmd.op == OP_READ);
          d.dq_oe     = 1'b1;
          d.phase     = (i_cmd.op == OP_RESET) ? PH_RST_LOW : PH_SLOT_LOW;
        end
      end
      PH_RST_LOW: begin
        if (at_us(q.us, RST_LOW_US, tick)) begin
          d.dq_oe    = 1'b0;
          d.us       = '0;
          d.presence = 1'b0;
          d.crc      = '0;
          d.phase    = PH_RST_HIGH;
        end
      end
      PH_RST_HIGH: begin
        if (at_us(q.us, PRES_SAMPLE_US, tick)) begin
          smp_pres   = 1'b1;
          d.presence = !line;
        end
        if (at_us(q.us, RST_HIGH_US, tick)) begin
          d.phase     = PH_IDLE;
          d.cmd_ready = 1'b1;
          d.done      = 1'b1;
        end
      end
      PH_SLOT_LOW: begin
        if (at_us(q.us, q.rd ? RD_LOW_US : (q.sh[0] ? W1_LOW_US : W0_LOW_US), tick)) begin
          d.dq_oe = 1'b0;
          d.phase = PH_SLOT_HIGH;
        end
      end
      PH_SLOT_HIGH: begin
        if (q.rd && at_us(q.us, RD_SAMPLE_US, tick)) begin
          smp_rd = 1'b1;
          d.sh   = {line, q.sh[7:1]};
          d.crc  = crc_step(q.crc, line);
        end
        if (at_us(q.us, SLOT_US, tick)) begin
          d.us    = '0;
          d.phase = PH_RECOV;
          if (!q.rd) begin
            d.sh = q.sh >> 1;
          end
        end
      end
      PH_RECOV: begin
        if (at_us(q.us, RECOV_US, tick)) begin
          if (q.bitn != LAST_BIT) begin
            d.bitn  = 3'(q.bitn + 1'b1);
            d.us    = '0;
            d.dq_oe = 1'b1;
            d.phase = PH_SLOT_LOW;
          end else if (q.rd) begin
            d.push      = 1'b1;
            d.push_data = q.sh;
            d.phase     = PH_PUSH;
          end else begin
            d.phase     = PH_IDLE;
            d.cmd_ready = 1'b1;
            d.done      = 1'b1;
          end
        end
      end
      PH_PUSH: begin
        // The line stays released while the FIFO is full, so a stalled user never holds the bus low.
        if (push_ready) begin
          d.push      = 1'b0;
          d.phase     = PH_IDLE;
          d.cmd_ready = 1'b1;
          d.done      = 1'b1;
        end
      end
      default: begin
        d = ST_RESET;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      q <= ST_RESET;
    end else begin
      q <= d;
    end
  end

  assign o_cmd_ready = q.cmd_ready;
  assign o_done      = q.done;
  assign o_presence  = q.presence;
  assign o_crc       = q.crc;
  assign o_dq_o      = q.dq_lvl;
  assign o_dq_oe     = q.dq_oe;

  // ****************************************************************
  // Read buffer
  // ****************************************************************
  sw_byte_fifo #(
    .W     (BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk_sys   (i_clk_sys),
    .i_nrst      (i_nrst),
    .i_in_valid  (q.push),
    .i_in_data   (q.push_data),
    .o_in_ready  (push_ready),
    .o_out_valid (o_rd_valid),
    .o_out_data  (o_rd_data),
    .i_out_ready (i_rd_ready)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic [16:0] low_cnt;
  logic [16:0] hi_cnt;
  logic [16:0] slot_cnt;
  logic        rst_gap;

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      // The line counts as long idle after reset, so the first slot is not mistaken for a short one.
      low_cnt  <= '0;
      hi_cnt   <= '1;
      slot_cnt <= '1;
      rst_gap  <= 1'b0;
    end else begin
      low_cnt  <= q.dq_oe ? ((&low_cnt) ? low_cnt : 17'(low_cnt + 1'b1)) : '0;
      hi_cnt   <= q.dq_oe ? '0 : ((&hi_cnt) ? hi_cnt : 17'(hi_cnt + 1'b1));
      slot_cnt <= (q.dq_oe && !low_cnt[0] && low_cnt == '0) ? 17'h0_0001 :
                  ((&slot_cnt) ? slot_cnt : 17'(slot_cnt + 1'b1));
      if (q.phase == PH_RST_HIGH) begin
        rst_gap <= 1'b1;
      end else if (q.dq_oe) begin
        rst_gap <= 1'b0;
      end
    end
  end

  sequence s_cmd_take(op_t op);
    i_cmd_valid && o_cmd_ready && i_cmd.op == op;
  endsequence

  sequence s_line_fall;
    $rose(o_dq_oe);
  endsequence

  sequence s_line_rise;
    $fell(o_dq_oe);
  endsequence

  AST_RST_START: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    s_cmd_take(OP_RESET) |=> o_dq_oe && q.phase == PH_RST_LOW ##1 o_dq_oe [*8])
    else $error("reset pulse did not start after a reset command");

  AST_RST_LOW_MIN: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    s_line_rise ##0 (q.phase == PH_RST_HIGH) |-> low_cnt >= 17'(RST_LOW_US * TICK_CYCLES))
    else $error("reset pulse shorter than its minimum");

  AST_LINE_LOW_MAX: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    low_cnt <= 17'(LINE_LOW_MAX_US * TICK_CYCLES))
    else $error("line held low beyond its limit");

  AST_RST_HIGH: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    s_line_fall ##0 rst_gap |-> hi_cnt >= 17'(RST_HIGH_US * TICK_CYCLES))
    else $error("new activity before reset high time expired");

  AST_WRITE_LOW: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    s_line_rise ##0 (q.phase == PH_SLOT_HIGH && !q.rd) |->
      (low_cnt <= 17'(W1_LOW_MAX_US * TICK_CYCLES) && low_cnt >= 17'(TICK_CYCLES)) ||
      (low_cnt >= 17'(W0_LOW_US * TICK_CYCLES) && low_cnt <= 17'(W0_LOW_MAX_US * TICK_CYCLES)))
    else $error("write slot low time out of range");

  AST_SLOT_SPACING: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    s_line_fall |-> slot_cnt >= 17'((SLOT_MIN_US + RECOV_MIN_US) * TICK_CYCLES)
      && hi_cnt >= 17'(RECOV_MIN_US * TICK_CYCLES))
    else $error("slot shorter than minimum or recovery missing");

  AST_READ_SAMPLE: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    smp_rd |-> !o_dq_oe && slot_cnt <= 17'(RD_SAMPLE_MAX_US * TICK_CYCLES)
      && slot_cnt > 17'(RD_LOW_US * TICK_CYCLES))
    else $error("read sample outside its window");

  AST_PRES_SAMPLE: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    smp_pres |-> hi_cnt >= 17'(PRES_MIN_US * TICK_CYCLES) && hi_cnt <= 17'(PRES_MAX_US * TICK_CYCLES))
    else $error("presence sampled outside its window");

  AST_IDLE_RELEASED: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    q.phase == PH_IDLE || q.phase == PH_PUSH |-> !o_dq_oe)
    else $error("line driven while idle");

  AST_READ_PUSH: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    $rose(q.push) |-> ##[0:1000] (q.push && push_ready) or !push_ready [*8])
    else $error("read byte neither stored nor held back");

endmodule

// file: verilog/sw_master_pkg.sv
// Shared constants and types of the single-wire bus master.
// Assumes a 100 MHz system clock; all line timing is counted in microsecond ticks.
package sw_master_pkg;

  // ****************************************************************
  // Clock and tick
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int US_NS         = 1000;
  localparam int US_CYCLES     = US_NS / CLK_PERIOD_NS;
  localparam int DIV_W         = 7;
  localparam int US_W          = 10;

  // ****************************************************************
  // Line timing in microseconds
  // ****************************************************************
  localparam int RST_LOW_US       = 480;
  localparam int RST_LOW_MAX_US   = 960;
  localparam int RST_HIGH_US      = 480;
  localparam int PRES_SAMPLE_US   = 70;
  localparam int PRES_MIN_US      = 60;
  localparam int PRES_MAX_US      = 75;
  localparam int W0_LOW_US        = 60;
  localparam int W0_LOW_MAX_US    = 120;
  localparam int W1_LOW_US        = 6;
  localparam int W1_LOW_MAX_US    = 15;
  localparam int RD_LOW_US        = 2;
  localparam int RD_SAMPLE_US     = 12;
  localparam int RD_SAMPLE_MAX_US = 15;
  localparam int SLOT_US          = 70;
  localparam int SLOT_MIN_US      = 61;
  localparam int RECOV_US         = 2;
  localparam int RECOV_MIN_US     = 1;
  localparam int LINE_LOW_MAX_US  = 960;

  // ****************************************************************
  // Data layout
  // ****************************************************************
  localparam int          BYTE_W     = 8;
  localparam int          FIFO_DEPTH = 32;
  localparam logic [7:0]  CRC_POLY   = 8'h8C;
  localparam logic [2:0]  LAST_BIT   = 3'h7;

  typedef enum logic [1:0] {OP_RESET, OP_WRITE, OP_READ} op_t;

  typedef struct packed {
    op_t        op;
    logic [7:0] data;
  } cmd_t;

  typedef enum logic [2:0] {
    PH_IDLE, PH_RST_LOW, PH_RST_HIGH, PH_SLOT_LOW, PH_SLOT_HIGH, PH_RECOV, PH_PUSH
  } phase_t;

  typedef struct packed {
    phase_t           phase;
    logic [US_W-1:0]  us;
    logic [DIV_W-1:0] div;
    logic [1:0]       sync;
    logic [2:0]       bitn;
    logic             rd;
    logic [7:0]       sh;
    logic [7:0]       crc;
    logic             presence;
    logic             dq_oe;
    logic             dq_lvl;
    logic             cmd_ready;
    logic             done;
    logic             push;
    logic [7:0]       push_data;
  } st_t;

  localparam st_t ST_RESET = '{
    phase:     PH_IDLE,
    us:        '0,
    div:       '0,
    sync:      2'h3,
    bitn:      '0,
    rd:        1'b0,
    sh:        '0,
    crc:       '0,
    presence:  1'b0,
    dq_oe:     1'b0,
    dq_lvl:    1'b0,
    cmd_ready: 1'b1,
    done:      1'b0,
    push:      1'b0,
    push_data: '0
  };

endpackage
